/* rtl/float_accel_pkg.sv */
// Shared types and constants of the floating-point accelerator.
// Assumes one clock shared with the host and a host that waits while busy.
// Behaviour
// - Opcode first, decoded into starting microaddress; the sequencer sends every opcode to UA_START (02).
// - After decode, prepare to take first operand.
// - Operands arrive as 32-bit words, buffered first.
// - Result normalized, packed, then buffered.
// - Result returned as 32-bit segments on bus.
// - Accelerator never touches memory itself.
// - Next address is latched pointer ORed status.
// - Host can force an arbitrary microaddress.
// - Host can read back the next microaddress.
// - Two parity bits checked on each microword.
// - Parity error branches to trap routine.
// - Float add, subtract, multiply, divide, integer ops.
// - Integers are 32-bit two's complement.
// - Normalize by shifts with exponent adjust.
// - Insert hidden bit on input, drop on output.
// - Exponent widths 8, 11 and 15 bits; the data path handles only the 8-bit width.
// - Exponent biases 80, 400, 4000 hexadecimal; the data path uses only BIAS_SD (80).
package float_accel_pkg;

    localparam int WORD_W = 32;
    localparam int UA_W = 5;
    localparam int FR_W = 26;
    localparam int EXPW_SD = 8;
    localparam int EXPW_G = 11;
    localparam int EXPW_H = 15;
    localparam logic [9:0] BIAS_SD = 10'h080;
    localparam logic [15:0] BIAS_G = 16'h0400;
    localparam logic [15:0] BIAS_H = 16'h4000;
    localparam int SIGN_POS = 31;
    localparam int EXP_LSB = 23;
    localparam int FRAC_W = 23;

    localparam logic [UA_W-1:0] UA_IDLE = 5'h00;
    localparam logic [UA_W-1:0] UA_START = 5'h02;
    localparam logic [UA_W-1:0] UA_TRAP = 5'h1F;

    localparam logic [2:0] OP_ADDF = 3'h0;
    localparam logic [2:0] OP_SUBF = 3'h1;
    localparam logic [2:0] OP_MULF = 3'h2;
    localparam logic [2:0] OP_DIVF = 3'h3;
    localparam logic [2:0] OP_ADDL = 3'h4;
    localparam logic [2:0] OP_SUBL = 3'h5;
    localparam logic [2:0] OP_MULL = 3'h6;

    typedef enum logic [10:0] {
        ACT_IDLE = 11'h001,
        ACT_LOAD_A = 11'h002,
        ACT_UNPK_A = 11'h004,
        ACT_LOAD_B = 11'h008,
        ACT_UNPK_B = 11'h010,
        ACT_EXEC = 11'h020,
        ACT_NORM = 11'h040,
        ACT_PACK = 11'h080,
        ACT_SEND = 11'h100,
        ACT_FINISH = 11'h200,
        ACT_TRAP = 11'h400
    } act_t;

    typedef enum logic [1:0] {
        BR_NONE = 2'h0,
        BR_WORD = 2'h1,
        BR_NDONE = 2'h2,
        BR_TAKEN = 2'h3
    } br_t;

    typedef struct packed {
        logic p1;
        logic p0;
        act_t act;
        br_t br;
        logic [UA_W-1:0] ptr;
    } uword_t;

    typedef struct packed {
        logic sign;
        logic zero;
        logic [9:0] exp;
        logic [23:0] mant;
    } operand_t;

    // Builds a microword with even parity: p0 over branch and pointer,
    // p1 over the action field.
    function automatic uword_t mk_uword(act_t a, br_t b, logic [4:0] p);
        uword_t w;
        w.act = a;
        w.br = b;
        w.ptr = p;
        w.p0 = ^{b, p};
        w.p1 = ^a;
        return w;
    endfunction : mk_uword

endpackage : float_accel_pkg

/* rtl/float_accelerator.sv */
// Data path and host port of the floating-point accelerator.
// Assumes the host shares clk_sys and drives its inputs on that clock.
`timescale 1ns/1ps
`default_nettype none
module float_accelerator (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [31:0] bus_in,
    output logic [31:0] bus_out,
    output logic bus_oe,
    input wire logic data_valid,
    output logic data_ready,
    output logic result_valid,
    input wire logic result_take,
    output logic busy,
    input wire logic force_valid,
    input wire logic [4:0] force_addr,
    input wire logic read_req,
    output logic [4:0] read_addr,
    output logic parity_err,
    output logic div_zero
);

    float_accel_pkg::act_t act;
    float_accel_pkg::operand_t a_ff, b_ff, nxt_a, nxt_b;
    logic [31:0] in_buf_ff, nxt_in_buf;
    logic [31:0] a_raw_ff, nxt_a_raw, b_raw_ff, nxt_b_raw;
    logic [31:0] res_ff, nxt_res, r_int_ff, nxt_r_int;
    logic [2:0] op_ff, nxt_op;
    logic [25:0] fr_ff, nxt_fr;
    logic [9:0] exp_ff, nxt_exp;
    logic sign_ff, nxt_sign, is_int_ff, nxt_is_int;
    logic perr_ff, nxt_perr, dz_ff, nxt_dz;
    logic st_word, st_ndone, st_taken, op_take;
    // Exec scratch values.
    float_accel_pkg::operand_t big, sml;
    logic [9:0] diff;
    logic [24:0] sum;
    logic [23:0] sm_sh;
    logic [47:0] prod, quot;
    logic [63:0] iprod;
    logic eff_sub;

    // Splits a packed word, restoring the hidden leading one.
    function automatic float_accel_pkg::operand_t unpack(logic [31:0] w);
        float_accel_pkg::operand_t o;
        o.sign = w[float_accel_pkg::SIGN_POS];
        o.exp = {2'b00, w[30:float_accel_pkg::EXP_LSB]};
        o.zero = (w[30:float_accel_pkg::EXP_LSB] == 8'h00);
        o.mant = o.zero ? 24'h000000 : {1'b1, w[22:0]};
        if (o.zero) begin
            o.sign = 1'b0;
        end
        return o;
    endfunction : unpack

    fp_microseq u_seq (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .op_valid(op_valid),
        .st_word(st_word),
        .st_ndone(st_ndone),
        .st_taken(st_taken),
        .force_valid(force_valid),
        .force_addr(force_addr),
        .read_req(read_req),
        .act(act),
        .busy(busy),
        .read_addr(read_addr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Host handshakes. There is no memory port: the host moves all data.
    // host supplies all data
    assign data_ready = (act == float_accel_pkg::ACT_LOAD_A) ||
                        (act == float_accel_pkg::ACT_LOAD_B);
    assign st_word = data_valid && data_ready;
    assign op_take = op_valid && (act == float_accel_pkg::ACT_IDLE) &&
                     !force_valid;
    assign result_valid = (act == float_accel_pkg::ACT_SEND);
    assign st_taken = result_valid && result_take;
    assign st_ndone = is_int_ff || (fr_ff == 26'h0) ||
                      (fr_ff[25:24] == 2'b00 && fr_ff[23]);
    assign bus_oe = result_valid;
    assign bus_out = res_ff;
    assign parity_err = perr_ff;
    assign div_zero = dz_ff;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic: single format floating point and 32-bit integers.
    always_comb begin
        eff_sub = b_ff.sign ^ a_ff.sign ^ (op_ff == float_accel_pkg::OP_SUBF);
        if (a_ff.exp > b_ff.exp ||
            (a_ff.exp == b_ff.exp && a_ff.mant >= b_ff.mant)) begin
            big = a_ff;
            sml = b_ff;
        end else begin
            big = b_ff;
            sml = a_ff;
            if (op_ff == float_accel_pkg::OP_SUBF) begin
                big.sign = ~b_ff.sign;
            end
        end
        diff = big.exp - sml.exp;
        // Alignment shifts smaller fraction right, one exponent step each.
        sm_sh = (diff > 10'd24) ? 24'h000000 : (sml.mant >> diff);
        sum = eff_sub ? ({1'b0, big.mant} - {1'b0, sm_sh})
                      : ({1'b0, big.mant} + {1'b0, sm_sh});
        prod = a_ff.mant * b_ff.mant;
        quot = (b_ff.mant == 24'h0) ? 48'h0 : ({a_ff.mant, 24'h0} /
               {24'h0, b_ff.mant});
        iprod = $signed({{32{a_raw_ff[31]}}, a_raw_ff}) *
                $signed({{32{b_raw_ff[31]}}, b_raw_ff});
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state of the data path, steered by the current microword.
    always_comb begin
        nxt_in_buf = in_buf_ff;
        nxt_a = a_ff;
        nxt_b = b_ff;
        nxt_a_raw = a_raw_ff;
        nxt_b_raw = b_raw_ff;
        nxt_op = op_ff;
        nxt_fr = fr_ff;
        nxt_exp = exp_ff;
        nxt_sign = sign_ff;
        nxt_is_int = is_int_ff;
        nxt_r_int = r_int_ff;
        nxt_res = res_ff;
        nxt_perr = perr_ff;
        nxt_dz = dz_ff;
        if (op_take) begin
            nxt_op = op_code;
            nxt_perr = 1'b0;
            nxt_dz = 1'b0;
        end
        if (st_word) begin
            nxt_in_buf = bus_in;
        end
        case (act)
            float_accel_pkg::ACT_UNPK_A: begin
                nxt_a = unpack(in_buf_ff);
                nxt_a_raw = in_buf_ff;
            end
            float_accel_pkg::ACT_UNPK_B: begin
                nxt_b = unpack(in_buf_ff);
                nxt_b_raw = in_buf_ff;
            end
            float_accel_pkg::ACT_EXEC: begin
                nxt_is_int = op_ff[2];
                case (op_ff)
                    float_accel_pkg::OP_ADDF, float_accel_pkg::OP_SUBF: begin
                        nxt_sign = big.sign;
                        nxt_exp = big.exp;
                        nxt_fr = {1'b0, sum};
                    end
                    float_accel_pkg::OP_MULF: begin
                        nxt_sign = a_ff.sign ^ b_ff.sign;
                        nxt_exp = a_ff.exp + b_ff.exp -
                                  float_accel_pkg::BIAS_SD;
                        nxt_fr = (a_ff.zero || b_ff.zero) ? 26'h0
                                 : {2'b00, prod[47:24]};
                    end
                    float_accel_pkg::OP_DIVF: begin
                        nxt_sign = a_ff.sign ^ b_ff.sign;
                        nxt_exp = a_ff.exp - b_ff.exp +
                                  float_accel_pkg::BIAS_SD;
                        nxt_fr = quot[25:0];
                        nxt_dz = b_ff.zero;
                    end
                    float_accel_pkg::OP_ADDL: nxt_r_int = a_raw_ff + b_raw_ff;
                    float_accel_pkg::OP_SUBL: nxt_r_int = a_raw_ff - b_raw_ff;
                    default: nxt_r_int = iprod[31:0];
                endcase
            end
            float_accel_pkg::ACT_NORM: begin
                if (!st_ndone && fr_ff[25:24] != 2'b00) begin
                    nxt_fr = {1'b0, fr_ff[25:1]};
                    nxt_exp = exp_ff + 10'd1;
                end else if (!st_ndone) begin
                    nxt_fr = {fr_ff[24:0], 1'b0};
                    nxt_exp = exp_ff - 10'd1;
                end
            end
            float_accel_pkg::ACT_PACK: begin
                if (is_int_ff) begin
                    nxt_res = r_int_ff;
                end else if (fr_ff == 26'h0) begin
                    nxt_res = 32'h00000000;
                end else begin
                    nxt_res = {sign_ff, exp_ff[7:0], fr_ff[22:0]};
                end
            end
            // Sticky until the next opcode; a trap in that cycle wins.
            float_accel_pkg::ACT_TRAP: nxt_perr = 1'b1;
            default: nxt_perr = nxt_perr;
        endcase
    end

    // Data path registers.
    // one shared clock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            in_buf_ff <= 32'h00000000;
            a_ff <= '0;
            b_ff <= '0;
            a_raw_ff <= 32'h00000000;
            b_raw_ff <= 32'h00000000;
            op_ff <= 3'h0;
            fr_ff <= 26'h0;
            exp_ff <= 10'h000;
            sign_ff <= 1'b0;
            is_int_ff <= 1'b0;
            r_int_ff <= 32'h00000000;
            res_ff <= 32'h00000000;
            perr_ff <= 1'b0;
            dz_ff <= 1'b0;
        end else begin
            in_buf_ff <= nxt_in_buf;
            a_ff <= nxt_a;
            b_ff <= nxt_b;
            a_raw_ff <= nxt_a_raw;
            b_raw_ff <= nxt_b_raw;
            op_ff <= nxt_op;
            fr_ff <= nxt_fr;
            exp_ff <= nxt_exp;
            sign_ff <= nxt_sign;
            is_int_ff <= nxt_is_int;
            r_int_ff <= nxt_r_int;
            res_ff <= nxt_res;
            perr_ff <= nxt_perr;
            dz_ff <= nxt_dz;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_first_word;
        act == float_accel_pkg::ACT_LOAD_A && st_word;
    endsequence
    sequence s_unpack_first;
        act == float_accel_pkg::ACT_UNPK_A && in_buf_ff == $past(bus_in);
    endsequence
    a_first_operand: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_take |=> act == float_accel_pkg::ACT_LOAD_A)
        else $error("no operand load after decode");
    a_word_buffered: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_first_word |=> s_unpack_first)
        else $error("first word not buffered before unpack");
    a_hidden_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (act == float_accel_pkg::ACT_UNPK_A && in_buf_ff[30:23] != 8'h00)
        |=> a_ff.mant[23])
        else $error("hidden bit not inserted");
    a_norm_right: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (act == float_accel_pkg::ACT_NORM && fr_ff[25:24] != 2'b00)
        |=> exp_ff == $past(exp_ff) + 10'd1)
        else $error("right shift without exponent increment");
    a_pack_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (act == float_accel_pkg::ACT_PACK && !is_int_ff && fr_ff[23])
        |=> res_ff == {$past(sign_ff), $past(exp_ff[7:0]),
                       $past(fr_ff[22:0])})
        else $error("packed result wrong");
    a_send_bus: assert property (@(posedge clk_sys) disable iff (!rst_n)
        result_valid |-> bus_oe && bus_out == res_ff)
        else $error("result not on bus");
    a_int_add: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (act == float_accel_pkg::ACT_EXEC && op_ff == 3'h4)
        |=> r_int_ff == $past(a_raw_ff) + $past(b_raw_ff))
        else $error("integer add wrong");

endmodule : float_accelerator
`default_nettype wire

/* rtl/fp_microseq.sv */
// Microsequencer with control store, parity check and diagnostics.
// Assumes status inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fp_microseq (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic st_word,
    input wire logic st_ndone,
    input wire logic st_taken,
    input wire logic force_valid,
    input wire logic [4:0] force_addr,
    input wire logic read_req,
    output float_accel_pkg::act_t act,
    output logic busy,
    output logic [4:0] read_addr
);

    logic [4:0] uaddr_ff;
    logic [4:0] nxt_uaddr;
    logic [4:0] read_addr_ff;
    logic [4:0] nxt_read_addr;
    float_accel_pkg::uword_t mw;
    logic par_err;
    logic st_bit;

    // Control store contents; every opcode starts at the same routine.
    function automatic float_accel_pkg::uword_t rom(logic [4:0] a);
        case (a)
            5'h00: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_IDLE, float_accel_pkg::BR_NONE, 5'h00);
            5'h02: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_LOAD_A, float_accel_pkg::BR_WORD, 5'h02);
            5'h03: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_UNPK_A, float_accel_pkg::BR_NONE, 5'h04);
            5'h04: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_LOAD_B, float_accel_pkg::BR_WORD, 5'h04);
            5'h05: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_UNPK_B, float_accel_pkg::BR_NONE, 5'h06);
            5'h06: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_EXEC, float_accel_pkg::BR_NONE, 5'h08);
            5'h08: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_NORM, float_accel_pkg::BR_NDONE, 5'h08);
            5'h09: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_PACK, float_accel_pkg::BR_NONE, 5'h0A);
            5'h0A: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_SEND, float_accel_pkg::BR_TAKEN, 5'h0A);
            5'h0B: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_FINISH, float_accel_pkg::BR_NONE, 5'h00);
            // Two diagnostic words hold a wrong parity bit each, one per
            // bit, so that a forced address can drive the trap path.
            5'h1D: begin
                rom = float_accel_pkg::mk_uword(float_accel_pkg::ACT_FINISH,
                    float_accel_pkg::BR_NONE, 5'h00);
                rom.p0 = ~rom.p0;
            end
            5'h1E: begin
                rom = float_accel_pkg::mk_uword(float_accel_pkg::ACT_FINISH,
                    float_accel_pkg::BR_NONE, 5'h00);
                rom.p1 = ~rom.p1;
            end
            5'h1F: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_TRAP, float_accel_pkg::BR_NONE, 5'h00);
            default: rom = float_accel_pkg::mk_uword(
                float_accel_pkg::ACT_TRAP, float_accel_pkg::BR_NONE, 5'h1F);
        endcase
    endfunction : rom

    assign mw = rom(uaddr_ff);
    assign par_err = (^{mw.p0, mw.br, mw.ptr}) | (^{mw.p1, mw.act});
    assign act = par_err ? float_accel_pkg::ACT_TRAP : mw.act;
    assign busy = (uaddr_ff != float_accel_pkg::UA_IDLE);
    assign read_addr = read_addr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Next address: force beats trap, trap beats dispatch and branching.
    always_comb begin
        case (mw.br)
            float_accel_pkg::BR_WORD: st_bit = st_word;
            float_accel_pkg::BR_NDONE: st_bit = st_ndone;
            float_accel_pkg::BR_TAKEN: st_bit = st_taken;
            default: st_bit = 1'b0;
        endcase
        nxt_read_addr = read_addr_ff;
        if (force_valid) begin
            nxt_uaddr = force_addr;
        end else if (par_err) begin
            nxt_uaddr = float_accel_pkg::UA_TRAP;
        end else if (mw.act == float_accel_pkg::ACT_IDLE && op_valid) begin
            nxt_uaddr = float_accel_pkg::UA_START;
        end else begin
            nxt_uaddr = mw.ptr | {4'h0, st_bit};
        end
        if (read_req) begin
            nxt_read_addr = nxt_uaddr;
        end
    end

    // Sequencer registers.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            uaddr_ff <= 5'h00;
            read_addr_ff <= 5'h00;
        end else begin
            uaddr_ff <= nxt_uaddr;
            read_addr_ff <= nxt_read_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_dispatch_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (act == float_accel_pkg::ACT_IDLE && op_valid && !force_valid)
        |=> uaddr_ff == 5'h02)
        else $error("opcode did not start routine");
    a_parity_trap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (par_err && !force_valid) |=> uaddr_ff == 5'h1F)
        else $error("parity error did not trap");
    a_force_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        force_valid |=> uaddr_ff == $past(force_addr))
        else $error("forced address not applied");
    a_branch_or: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!force_valid && !par_err && mw.act != float_accel_pkg::ACT_IDLE)
        |=> uaddr_ff == ($past(mw.ptr) | {4'h0, $past(st_bit)}))
        else $error("next address not pointer OR status");
    a_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
        read_req |=> read_addr == uaddr_ff)
        else $error("read back differs from applied address");

endmodule : fp_microseq
`default_nettype wire

/* tb/host_model.sv */
// Host side of the accelerator port: opcodes, operands, results.
// Assumes one shared clock; drives on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk_sys,
    output logic op_valid,
    output logic [2:0] op_code,
    output logic [31:0] bus_in,
    output logic data_valid,
    output logic result_take,
    input wire logic data_ready,
    input wire logic result_valid,
    input wire logic bus_oe,
    input wire logic [31:0] bus_out
);
    initial begin
        op_valid = 1'b0;
        op_code = 3'h0;
        bus_in = 32'hA5A5A5A5;
        data_valid = 1'b0;
        result_take = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // opcode goes first
    // A hold above one offers a second opcode while busy, on purpose.
    task automatic send_op(input logic [2:0] code, input int hold);
        @(negedge clk_sys);
        op_valid = 1'b1;
        op_code = code;
        @(negedge clk_sys);
        op_code = code ^ 3'h1;
        repeat (hold - 1) @(negedge clk_sys);
        op_valid = 1'b0;
    endtask : send_op

    // whole operand words
    // A released bus shows the inverse, so stale data cannot pass.
    task automatic send_word(input logic [31:0] w, input int lag);
        repeat (lag + 1) @(negedge clk_sys);
        data_valid = 1'b1;
        bus_in = w;
        while (data_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        data_valid = 1'b0;
        bus_in = ~w;
    endtask : send_word

    task automatic take_result(input int lag, output logic [31:0] res,
                               output logic oe, output logic stood);
        @(negedge clk_sys);
        while (result_valid !== 1'b1) @(negedge clk_sys);
        res = bus_out;
        oe = bus_oe;
        repeat (lag) @(negedge clk_sys);
        stood = result_valid && (bus_out === res);
        result_take = 1'b1;
        @(negedge clk_sys);
        result_take = 1'b0;
    endtask : take_result
endmodule : host_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the accelerator with a host model.
// Assumes a 10 MHz shared clock and inputs moved on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n, op_valid, data_valid, data_ready, result_valid;
    logic result_take, bus_oe, busy, force_valid, read_req;
    logic parity_err, div_zero;
    logic [2:0] op_code;
    logic [4:0] force_addr, read_addr;
    logic [31:0] bus_in, bus_out;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;

    always #50 clk_sys = ~clk_sys;

    float_accelerator dut (.clk_sys, .rst_n, .op_valid, .op_code,
        .bus_in, .bus_out, .bus_oe, .data_valid, .data_ready,
        .result_valid, .result_take, .busy, .force_valid, .force_addr,
        .read_req, .read_addr, .parity_err, .div_zero);
    host_model host (.clk_sys, .op_valid, .op_code, .bus_in, .data_valid,
        .result_take, .data_ready, .result_valid, .bus_oe, .bus_out);

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic check_bit(input string what, input logic seen, exp);
        check(what, {31'h0, seen}, {31'h0, exp});
    endtask : check_bit

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // A hang counts as a mismatch; the whole run needs fewer than 200 cycles.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One instruction end to end, with host lag and an optional refusal.
    task automatic do_op(input logic [2:0] code, input logic [31:0] a, b,
                         exp, input logic dz, input int lag, hold);
        logic [31:0] res;
        logic oe, stood;
        host.send_op(code, hold);
        check_bit("busy", busy, 1'b1);
        check_bit("ready_a", data_ready, 1'b1);
        check_bit("dz_clear", div_zero, 1'b0);
        host.send_word(a, lag);
        check_bit("unpack", data_ready, 1'b0);
        host.send_word(b, 0);
        host.take_result(lag, res, oe, stood);
        check("result", res, exp);
        check_bit("oe", oe, 1'b1);
        check_bit("stood", stood, 1'b1);
        check_bit("finish", busy, 1'b1);
        check_bit("dz", div_zero, dz);
        check_bit("parity", parity_err, 1'b0);
        @(negedge clk_sys);
        check_bit("idle", busy, 1'b0);
        check_bit("released", bus_oe, 1'b0);
    endtask : do_op

    // Force and read-back of the microaddress from the host side.
    task automatic diag_check;
        for (int i = 0; i < 2; i++) begin
            @(negedge clk_sys);
            force_valid = 1'b1;
            force_addr = (i == 0) ? 5'h1D : 5'h1E;
            @(negedge clk_sys);
            force_valid = 1'b0;
            read_req = 1'b1;
            @(negedge clk_sys);
            read_req = 1'b0;
            check("rd_trap", {27'h0, read_addr}, 32'h1F);
            check_bit("perr", parity_err, 1'b1);
        end
        @(negedge clk_sys);
        read_req = 1'b1;
        @(negedge clk_sys);
        check("rd_idle", {27'h0, read_addr}, 32'h0);
        force_valid = 1'b1;
        force_addr = float_accel_pkg::UA_START;
        @(negedge clk_sys);
        check("rd_forced", {27'h0, read_addr}, 32'h2);
        check_bit("forced_busy", busy, 1'b1);
        force_addr = float_accel_pkg::UA_IDLE;
        @(negedge clk_sys);
        force_valid = 1'b0;
        read_req = 1'b0;
        check_bit("forced_idle", busy, 1'b0);
        check("rd_back", {27'h0, read_addr}, 32'h0);
    endtask : diag_check

    // Reset in mid-instruction must drop every handshake at once.
    task automatic reset_mid;
        host.send_op(float_accel_pkg::OP_MULF, 1);
        host.send_word(32'h41E00000, 0);
        check_bit("perr_clear", parity_err, 1'b0);
        rst_n = 1'b0;
        #10;
        check_bit("rst_busy", busy, 1'b0);
        check_bit("rst_ready", data_ready, 1'b0);
        check_bit("rst_res", result_valid, 1'b0);
        check_bit("rst_oe", bus_oe, 1'b0);
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
    endtask : reset_mid

    initial begin
        rst_n = 1'b0;
        force_valid = 1'b0;
        force_addr = 5'h00;
        read_req = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        do_op(float_accel_pkg::OP_ADDF, 32'h43200000, 32'h41E00000,
              32'h433C0000, 1'b0, 0, 1);
        do_op(float_accel_pkg::OP_SUBF, 32'h43200000, 32'h41E00000,
              32'h43040000, 1'b0, 2, 3);
        do_op(float_accel_pkg::OP_MULF, 32'h41E00000, 32'h43200000,
              32'h448C0000, 1'b0, 1, 1);
        do_op(float_accel_pkg::OP_DIVF, 32'h42700000, 32'h41A00000,
              32'h41400000, 1'b0, 0, 1);
        do_op(float_accel_pkg::OP_DIVF, 32'h42700000, 32'h00000000,
              32'h00000000, 1'b1, 3, 1);
        do_op(float_accel_pkg::OP_ADDL, 32'h80000000, 32'h7FFFFFFF,
              32'hFFFFFFFF, 1'b0, 0, 1);
        do_op(float_accel_pkg::OP_SUBL, 32'h00000005, 32'h00000007,
              32'hFFFFFFFE, 1'b0, 1, 1);
        do_op(float_accel_pkg::OP_MULL, 32'hFFFFFFFD, 32'h00000004,
              32'hFFFFFFF4, 1'b0, 2, 1);
        do_op(3'h7, 32'h00000006, 32'h00000007, 32'h0000002A, 1'b0, 0, 1);
        diag_check();
        reset_mid();
        do_op(float_accel_pkg::OP_ADDF, 32'h43200000, 32'h41E00000,
              32'h433C0000, 1'b0, 0, 1);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
